// ==== bench/pem_chk_monitor.sv ====
// Checker of bus timing and warning behaviour at the monitor's ports.
// Assumes binding to every instance of the monitor.
`timescale 1ns/1ps
module pem_chk_monitor
(
    // Clock and reset.
    input wire clock,
    input wire rst_b,
    // Observed ports.
    input wire sample_valid,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire [6:0] warn_status
);
    wire taken = hsel && hready && htrans[1];
    reg ctl_dp_ff;
    reg ctl_done_ff;
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_dp_ff <= 1'b0;
            ctl_done_ff <= 1'b0;
        end
        else
        begin
            ctl_dp_ff <= taken && hwrite && haddr[7:2] == 6'h00;
            ctl_done_ff <= ctl_dp_ff;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (
        taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (
        taken && hwrite |=> hreadyout)
        else $error("write was stalled");
    a_idle_ready: assert property (
        !(taken && !hwrite) |=> hreadyout)
        else $error("stall without read");
    a_rdata_hold: assert property (
        !$stable(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data changed outside a read");
    a_warn_latch: assert property (
        |(~warn_status & $past(warn_status)) |-> ctl_dp_ff || ctl_done_ff)
        else $error("warning dropped without clear");
    a_warn_cause: assert property (
        |(warn_status & ~$past(warn_status)) |-> $past(sample_valid, 2))
        else $error("warning set without a sample");
    a_warn_quiet: assert property (
        !$past(sample_valid, 2) && !ctl_dp_ff && !ctl_done_ff
        |-> $stable(warn_status))
        else $error("warnings moved while idle");
endmodule
bind pem_monitor pem_chk_monitor u_pem_chk_monitor (.clock(clock),
    .rst_b(rst_b), .sample_valid(sample_valid), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .warn_status(warn_status));

// ==== bench/pem_sample_src.sv ====
// Averaging-stage model: one strobe for each clock cycle in which req is high.
// Assumes the bench raises req just after a rising clock edge.
`timescale 1ns/1ps
module pem_sample_src
(
    // Clock and reset.
    input wire clock,
    input wire rst_b,
    // Request from the bench.
    input wire req,
    input wire [35:0] codes,
    // Averaged set to the monitor.
    output logic sample_valid,
    output logic [35:0] avg_set
);
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_valid <= 1'b0;
            avg_set <= 36'h0;
        end
        else
        begin
            sample_valid <= req;
            // Codes are valid only in the strobe cycle.
            avg_set <= req ? codes : ~avg_set;
        end
    end
endmodule

// ==== bench/power_energy_accum_monitor_tb.sv ====
// Self-checking bench of the power and energy monitor.
// Assumes the monitor is the only slave on its register bus.
`timescale 1ns/1ps
`include "pem_defs.vh"
module power_energy_accum_monitor_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    logic [35:0] src_codes = 36'h0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire sample_valid;
    wire [35:0] avg_set;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire [6:0] warn_status;
    logic [31:0] rdat;
    logic [23:0] acc = 24'h0;
    logic [15:0] roll = 16'h0;
    logic [23:0] cnt = 24'h0;
    int n_errors = 0;
    int n_compared = 0;
    int k;
    always #4 clock = ~clock;
    pem_sample_src u_pem_sample_src (.clock(clock), .rst_b(rst_b),
        .req(req), .codes(src_codes), .sample_valid(sample_valid),
        .avg_set(avg_set));
    pem_monitor u_pem_monitor (.clock(clock), .rst_b(rst_b),
        .sample_valid(sample_valid), .vin_code(avg_set[35:24]),
        .vout_code(avg_set[23:12]), .iout_code(avg_set[11:0]),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .warn_status(warn_status));
    task end_sim;
        begin
            $display("errors %0d compared %0d", n_errors, n_compared);
            if (n_errors == 0 && n_compared > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_compared++;
            if (got !== exp)
            begin
                n_errors++;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'b10;
            haddr <= a;
            hwrite <= w;
            @(negedge clock);
            while (hreadyout !== 1'b1) @(negedge clock);
            @(posedge clock);
            htrans <= 2'b00;
            hwdata <= d;
            @(negedge clock);
            while (hreadyout !== 1'b1) @(negedge clock);
            rdat = hrdata;
            @(posedge clock);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        begin
            bus(1'b0, a, 32'h0);
            chk(rdat, exp);
        end
    endtask
    task wchk(input logic [6:0] e);
        begin
            repeat (2) @(negedge clock);
            chk({25'h0, warn_status}, {25'h0, e});
            @(posedge clock);
        end
    endtask
    task smp(input logic [35:0] c, input int n);
        int i;
        logic [23:0] p;
        begin
            p = {12'h0, c[35:24]} * {12'h0, c[11] ? 12'h000 : c[11:0]};
            for (i = 0; i < n; i++)
            begin
                acc = acc + p;
                if (acc[23])
                    roll++;
                acc[23] = 1'b0;
                cnt++;
            end
            req <= 1'b1;
            src_codes <= c;
            repeat (n) @(posedge clock);
            req <= 1'b0;
            repeat (5) @(posedge clock);
        end
    endtask
    function logic [35:0] cs(input int k, input logic b);
        logic [11:0] v;
        logic [11:0] o;
        logic [11:0] i;
        begin
            v = 12'h400;
            o = 12'h400;
            i = 12'h100;
            case (k)
                0: v = b ? 12'h501 : 12'h500;
                1: v = b ? 12'h2FF : 12'h300;
                2: o = b ? 12'h501 : 12'h500;
                3: o = b ? 12'h2FF : 12'h300;
                4: i = b ? 12'h201 : 12'h200;
                5: i = b ? 12'h07F : 12'h080;
                6:
                begin
                    v = b ? 12'h481 : 12'h480;
                    i = 12'h200;
                end
                default: v = 12'h400;
            endcase
            cs = {v, o, i};
        end
    endfunction
    task t_reset;
        begin
            rchk(`PEM_A_TH_VIN_OV, 32'h7FFF);
            rchk(`PEM_A_TH_VIN_UV, 32'h0);
            rchk(`PEM_A_TH_VOUT_OV, 32'h7FFF);
            rchk(`PEM_A_TH_VOUT_UV, 32'h0);
            rchk(`PEM_A_TH_CUR_OC, 32'h7FFF);
            rchk(`PEM_A_TH_PWR_OP, 32'h7FFF);
            rchk(`PEM_A_STATUS, 32'h0);
            rchk(8'h2C, 32'h0);
        end
    endtask
    task t_power;
        begin
            smp({12'hABC, 12'h123, 12'h7FF}, 1);
            rchk(`PEM_A_PWR_EXT, 32'h55D544);
            smp({12'hFFF, 12'h123, 12'h7FF}, 1);
            rchk(`PEM_A_PWR_EXT, 32'h7FE801);
            rchk(`PEM_A_PWR, 32'h7FE8);
            rchk(`PEM_A_VIN, 32'hFFF);
            smp({12'hFFF, 12'h123, 12'h800}, 1);
            rchk(`PEM_A_PWR_EXT, 32'h0);
        end
    endtask
    task t_peak;
        begin
            for (k = 0; k < 4; k++)
                bus(1'b1, 8'h30 + 8'(k * 4), 32'h0);
            smp({12'h600, 12'h500, 12'h300}, 1);
            smp({12'h200, 12'h700, 12'h100}, 1);
            rchk(`PEM_A_PK_CUR, 32'h300);
            rchk(`PEM_A_PK_VIN, 32'h600);
            rchk(`PEM_A_PK_VOUT, 32'h700);
            rchk(`PEM_A_PK_PWR, 32'h1200);
            bus(1'b1, `PEM_A_PK_VIN, 32'h0);
            bus(1'b1, `PEM_A_PK_CUR, 32'h5);
            rchk(`PEM_A_PK_VIN, 32'h0);
            rchk(`PEM_A_PK_CUR, 32'h300);
            rchk(`PEM_A_PK_VOUT, 32'h700);
        end
    endtask
    task t_warn;
        begin
            bus(1'b1, `PEM_A_TH_VIN_OV, 32'h500);
            bus(1'b1, `PEM_A_TH_VIN_UV, 32'h300);
            bus(1'b1, `PEM_A_TH_VOUT_OV, 32'h500);
            bus(1'b1, `PEM_A_TH_VOUT_UV, 32'h300);
            bus(1'b1, `PEM_A_TH_CUR_OC, 32'h200);
            bus(1'b1, `PEM_A_TH_CUR2, 32'h80);
            bus(1'b1, `PEM_A_TH_PWR_OP, 32'h900);
            bus(1'b1, `PEM_A_CTRL, 32'h4);
            for (k = 0; k < 7; k++)
            begin
                smp(cs(k, 1'b0), 1);
                wchk(7'h0);
                smp(cs(k, 1'b1), 1);
                wchk(7'(1 << k));
                bus(1'b1, `PEM_A_CTRL, 32'h5);
                wchk(7'(1 << k));
                smp(cs(9, 1'b0), 1);
                wchk(7'(1 << k));
                bus(1'b1, `PEM_A_CTRL, 32'h5);
                wchk(7'h0);
            end
            smp(cs(0, 1'b1), 1);
            smp(cs(9, 1'b0), 1);
            rchk(`PEM_A_STATUS, 32'h1);
            bus(1'b1, `PEM_A_CTRL, 32'h0);
            bus(1'b1, `PEM_A_CTRL, 32'h4);
            wchk(7'h0);
            bus(1'b1, `PEM_A_CTRL, 32'h6);
            smp(cs(9, 1'b0), 1);
            rchk(`PEM_A_STATUS, 32'h20);
        end
    endtask
    task t_energy;
        begin
            // The rollover count wraps once here, as a host would allow.
            smp({12'hFFF, 12'h000, 12'h7FF}, 65600);
            rchk(`PEM_A_EN_EXT, {8'h0, acc});
            rchk(`PEM_A_SNAP_ROLL, {16'h0, roll});
            rchk(`PEM_A_SNAP_SMP, {8'h0, cnt});
            rchk(`PEM_A_EN_SHORT, {8'h0, roll[7:0], acc[23:8]});
        end
    endtask
    initial
    begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_reset;
        t_power;
        t_peak;
        t_warn;
        t_energy;
        end_sim;
    end
    initial
    begin
        #640000;
        n_errors++;
        end_sim;
    end
endmodule

// ==== hdl/pem_defs.vh ====
// Constants of the power and energy monitor: register offsets,
// status bit positions and reset values of the warning thresholds.
// Assumes inclusion by bare name from the design file.
`ifndef PEM_DEFS_VH
`define PEM_DEFS_VH
`define PEM_A_CTRL 8'h00
`define PEM_A_STATUS 8'h04
`define PEM_A_VIN 8'h08
`define PEM_A_VOUT 8'h0C
`define PEM_A_IOUT 8'h10
`define PEM_A_PWR 8'h14
`define PEM_A_PWR_EXT 8'h18
`define PEM_A_EN_SHORT 8'h1C
`define PEM_A_SNAP_SMP 8'h20
`define PEM_A_EN_EXT 8'h24
`define PEM_A_SNAP_ROLL 8'h28
`define PEM_A_PK_CUR 8'h30
`define PEM_A_PK_VIN 8'h34
`define PEM_A_PK_VOUT 8'h38
`define PEM_A_PK_PWR 8'h3C
`define PEM_A_TH_VIN_OV 8'h40
`define PEM_A_TH_VIN_UV 8'h44
`define PEM_A_TH_VOUT_OV 8'h48
`define PEM_A_TH_VOUT_UV 8'h4C
`define PEM_A_TH_CUR_OC 8'h50
`define PEM_A_TH_CUR2 8'h54
`define PEM_A_TH_PWR_OP 8'h58
`define PEM_CTRL_CLR 0
`define PEM_CTRL_POL2 1
`define PEM_CTRL_OUT_ON 2
`define PEM_ST_VIN_OV 0
`define PEM_ST_VIN_UV 1
`define PEM_ST_VOUT_OV 2
`define PEM_ST_VOUT_UV 3
`define PEM_ST_CUR_OC 4
`define PEM_ST_CUR2 5
`define PEM_ST_PWR_OP 6
`define PEM_TH_MAX 16'h7FFF
`define PEM_TH_MIN 16'h0000
`define PEM_ACC_MASK 24'h7FFFFF
`define PEM_TRANS_NONSEQ 2'b10
`define PEM_TRANS_SEQ 2'b11
`endif

// ==== hdl/pem_monitor.v ====
// Power, energy, peak and warning logic of a power monitor, with an
// AHB-Lite register slave. Assumes averaged codes and their strobe come
// from logic on the same clock, and that it is the only bus slave.
`timescale 1ns/1ps
`include "pem_defs.vh"

module pem_monitor
(
    // Clock and reset.
    input wire clock,
    input wire rst_b,
    // Averaged measurement set.
    input wire sample_valid,
    input wire [11:0] vin_code,
    input wire [11:0] vout_code,
    input wire [11:0] iout_code,
    // AHB-Lite slave.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    // Status.
    output wire [6:0] warn_status
);

    // Bus state.
    reg wr_pend_ff;
    reg rd_pend_ff;
    reg [7:0] addr_ff;
    reg [31:0] rdata_ff;
    // Measurement pipeline.
    reg stg_ff;
    reg [11:0] vin_ff;
    reg [11:0] vout_ff;
    reg [11:0] cur_ff;
    reg [23:0] pwr_ff;
    // Energy.
    reg [23:0] acc_ff;
    reg [15:0] roll_ff;
    reg [23:0] smp_ff;
    reg [15:0] snap_roll_ff;
    reg [23:0] snap_smp_ff;
    // Peaks.
    reg [15:0] pk_cur_ff;
    reg [15:0] pk_vin_ff;
    reg [15:0] pk_vout_ff;
    reg [15:0] pk_pwr_ff;
    // Thresholds, control and warning state.
    reg [15:0] th_vin_ov_ff;
    reg [15:0] th_vin_uv_ff;
    reg [15:0] th_vout_ov_ff;
    reg [15:0] th_vout_uv_ff;
    reg [15:0] th_cur_oc_ff;
    reg [15:0] th_cur2_ff;
    reg [15:0] th_pwr_op_ff;
    reg pol2_ff;
    reg out_on_ff;
    reg [6:0] cond_ff;
    reg [6:0] st_ff;

    wire acc_take;
    wire rd_take;
    wire wr_take;
    wire wr_now;
    wire zero_wr;
    wire clr_now;
    wire out_rise;
    wire [11:0] cur_pos;
    wire [23:0] acc_sum;
    wire [6:0] cond;
    wire pk_clr_cur;
    wire pk_clr_vin;
    wire pk_clr_vout;
    wire pk_clr_pwr;
    reg [31:0] nxt_rdata;

    // Signed compare of a measurement word against a threshold word.
    function above;
        input [15:0] val;
        input [15:0] lim;
        begin
            above = $signed(val) > $signed(lim);
        end
    endfunction

    // Widens a 12-bit code to a 16-bit word.
    function [15:0] wide;
        input [11:0] code;
        begin
            wide = {4'h0, code};
        end
    endfunction

    // Next value of a peak hold. A zero write restarts the hold, from the
    // sample of the same cycle if one arrives, so that sample is not lost.
    function [15:0] peak_next;
        input [15:0] held;
        input [15:0] seen;
        input fresh;
        input clear;
        begin
            if (clear)
            begin
                peak_next = fresh ? seen : 16'h0000;
            end
            else if (fresh && seen > held)
            begin
                peak_next = seen;
            end
            else
            begin
                peak_next = held;
            end
        end
    endfunction

    assign acc_take = hsel & hready & htrans[1];
    assign rd_take = acc_take & ~hwrite;
    assign wr_take = acc_take & hwrite;
    assign wr_now = wr_pend_ff;
    assign zero_wr = wr_now & (hwdata == 32'h0000_0000);
    assign clr_now = wr_now & (addr_ff == `PEM_A_CTRL)
        & hwdata[`PEM_CTRL_CLR];
    assign out_rise = wr_now & (addr_ff == `PEM_A_CTRL)
        & hwdata[`PEM_CTRL_OUT_ON] & ~out_on_ff;
    assign hreadyout = ~rd_pend_ff;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign warn_status = st_ff;
    assign pk_clr_cur = zero_wr & (addr_ff == `PEM_A_PK_CUR);
    assign pk_clr_vin = zero_wr & (addr_ff == `PEM_A_PK_VIN);
    assign pk_clr_vout = zero_wr & (addr_ff == `PEM_A_PK_VOUT);
    assign pk_clr_pwr = zero_wr & (addr_ff == `PEM_A_PK_PWR);

    // Current code counts as positive only with clear sign and nonzero.
    assign cur_pos = (iout_code[11] | (iout_code == 12'h000)) ?
        12'h000 : iout_code;

    // Both terms stay below 2^23, so the sum never carries out of 24 bits.
    assign acc_sum = acc_ff + pwr_ff;

    assign cond[`PEM_ST_VIN_OV] = above(wide(vin_ff), th_vin_ov_ff);
    assign cond[`PEM_ST_VIN_UV] = above(th_vin_uv_ff, wide(vin_ff));
    assign cond[`PEM_ST_VOUT_OV] = above(wide(vout_ff), th_vout_ov_ff);
    assign cond[`PEM_ST_VOUT_UV] = above(th_vout_uv_ff, wide(vout_ff));
    assign cond[`PEM_ST_CUR_OC] = above(wide(cur_ff), th_cur_oc_ff);
    assign cond[`PEM_ST_CUR2] = pol2_ff ?
        above(wide(cur_ff), th_cur2_ff) :
        above(th_cur2_ff, wide(cur_ff));
    assign cond[`PEM_ST_PWR_OP] = above(pwr_ff[23:8], th_pwr_op_ff);

    // Read data mux, 16-bit words zero extended.
    always @*
    begin
        case (addr_ff)
            `PEM_A_CTRL: nxt_rdata = {29'h0, out_on_ff, pol2_ff, 1'b0};
            `PEM_A_STATUS: nxt_rdata = {25'h0, st_ff};
            `PEM_A_VIN: nxt_rdata = {16'h0, wide(vin_ff)};
            `PEM_A_VOUT: nxt_rdata = {16'h0, wide(vout_ff)};
            `PEM_A_IOUT: nxt_rdata = {16'h0, wide(cur_ff)};
            `PEM_A_PWR: nxt_rdata = {16'h0, pwr_ff[23:8]};
            `PEM_A_PWR_EXT: nxt_rdata = {8'h0, pwr_ff};
            `PEM_A_EN_SHORT: nxt_rdata = {8'h0, roll_ff[7:0],
                acc_ff[23:8]};
            `PEM_A_SNAP_SMP: nxt_rdata = {8'h0, snap_smp_ff};
            `PEM_A_EN_EXT: nxt_rdata = {8'h0, acc_ff};
            `PEM_A_SNAP_ROLL: nxt_rdata = {16'h0, snap_roll_ff};
            `PEM_A_PK_CUR: nxt_rdata = {16'h0, pk_cur_ff};
            `PEM_A_PK_VIN: nxt_rdata = {16'h0, pk_vin_ff};
            `PEM_A_PK_VOUT: nxt_rdata = {16'h0, pk_vout_ff};
            `PEM_A_PK_PWR: nxt_rdata = {16'h0, pk_pwr_ff};
            `PEM_A_TH_VIN_OV: nxt_rdata = {16'h0, th_vin_ov_ff};
            `PEM_A_TH_VIN_UV: nxt_rdata = {16'h0, th_vin_uv_ff};
            `PEM_A_TH_VOUT_OV: nxt_rdata = {16'h0, th_vout_ov_ff};
            `PEM_A_TH_VOUT_UV: nxt_rdata = {16'h0, th_vout_uv_ff};
            `PEM_A_TH_CUR_OC: nxt_rdata = {16'h0, th_cur_oc_ff};
            `PEM_A_TH_CUR2: nxt_rdata = {16'h0, th_cur2_ff};
            `PEM_A_TH_PWR_OP: nxt_rdata = {16'h0, th_pwr_op_ff};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Bus phases: writes take no wait, reads take one wait state.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            snap_roll_ff <= 16'h0000;
            snap_smp_ff <= 24'h000000;
        end
        else
        begin
            wr_pend_ff <= wr_take;
            rd_pend_ff <= rd_take;
            if (acc_take)
            begin
                addr_ff <= {haddr[7:2], 2'b00};
            end
            if (rd_pend_ff)
            begin
                rdata_ff <= nxt_rdata;
                // Snapshot makes the energy set coherent.
                if (addr_ff == `PEM_A_EN_SHORT ||
                    addr_ff == `PEM_A_EN_EXT)
                begin
                    snap_roll_ff <= roll_ff;
                    snap_smp_ff <= smp_ff;
                end
            end
        end
    end

    // Control and threshold registers.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            th_vin_ov_ff <= `PEM_TH_MAX;
            th_vin_uv_ff <= `PEM_TH_MIN;
            th_vout_ov_ff <= `PEM_TH_MAX;
            th_vout_uv_ff <= `PEM_TH_MIN;
            th_cur_oc_ff <= `PEM_TH_MAX;
            th_cur2_ff <= `PEM_TH_MAX;
            th_pwr_op_ff <= `PEM_TH_MAX;
            pol2_ff <= 1'b1;
            out_on_ff <= 1'b1;
        end
        else if (wr_now)
        begin
            case (addr_ff)
                `PEM_A_CTRL:
                begin
                    pol2_ff <= hwdata[`PEM_CTRL_POL2];
                    out_on_ff <= hwdata[`PEM_CTRL_OUT_ON];
                end
                `PEM_A_TH_VIN_OV: th_vin_ov_ff <= hwdata[15:0];
                `PEM_A_TH_VIN_UV: th_vin_uv_ff <= hwdata[15:0];
                `PEM_A_TH_VOUT_OV: th_vout_ov_ff <= hwdata[15:0];
                `PEM_A_TH_VOUT_UV: th_vout_uv_ff <= hwdata[15:0];
                `PEM_A_TH_CUR_OC: th_cur_oc_ff <= hwdata[15:0];
                `PEM_A_TH_CUR2: th_cur2_ff <= hwdata[15:0];
                `PEM_A_TH_PWR_OP: th_pwr_op_ff <= hwdata[15:0];
                default:
                begin
                end
            endcase
        end
    end

    // Stage one: capture averaged codes and form the product.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stg_ff <= 1'b0;
            vin_ff <= 12'h000;
            vout_ff <= 12'h000;
            cur_ff <= 12'h000;
            pwr_ff <= 24'h000000;
        end
        else
        begin
            stg_ff <= sample_valid;
            if (sample_valid)
            begin
                vin_ff <= vin_code;
                vout_ff <= vout_code;
                cur_ff <= iout_code;
                pwr_ff <= vin_code * cur_pos;
            end
        end
    end

    // Stage two: energy, counters and peaks.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_ff <= 24'h000000;
            roll_ff <= 16'h0000;
            smp_ff <= 24'h000000;
            pk_cur_ff <= 16'h0000;
            pk_vin_ff <= 16'h0000;
            pk_vout_ff <= 16'h0000;
            pk_pwr_ff <= 16'h0000;
        end
        else
        begin
            if (stg_ff)
            begin
                acc_ff <= acc_sum & `PEM_ACC_MASK;
                if (acc_sum[23])
                begin
                    roll_ff <= roll_ff + 16'h0001;
                end
                smp_ff <= smp_ff + 24'h000001;
            end
            // Each peak follows only its own clear and averaged samples.
            pk_cur_ff <= peak_next(pk_cur_ff, wide(cur_ff), stg_ff,
                pk_clr_cur);
            pk_vin_ff <= peak_next(pk_vin_ff, wide(vin_ff), stg_ff,
                pk_clr_vin);
            pk_vout_ff <= peak_next(pk_vout_ff, wide(vout_ff), stg_ff,
                pk_clr_vout);
            pk_pwr_ff <= peak_next(pk_pwr_ff, pwr_ff[23:8], stg_ff,
                pk_clr_pwr);
        end
    end

    // Stage two: warning conditions and latched status.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cond_ff <= 7'h00;
            st_ff <= 7'h00;
        end
        else
        begin
            if (stg_ff)
            begin
                cond_ff <= cond;
            end
            if (clr_now || out_rise)
            begin
                // Persisting conditions set again at once.
                st_ff <= cond_ff | (stg_ff ? cond : 7'h00);
            end
            else if (stg_ff)
            begin
                st_ff <= st_ff | cond;
            end
        end
    end

endmodule
